// [timer16_pkg.sv]
// Shared constants and types of the 16-bit compare/capture timer
package timer16_pkg;

    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_status = 8'h04;
    localparam logic [7:0] off_mask = 8'h08;
    localparam logic [7:0] off_cmp1_hi = 8'h0c;
    localparam logic [7:0] off_cmp1_lo = 8'h10;
    localparam logic [7:0] off_cmp2_hi = 8'h14;
    localparam logic [7:0] off_cmp2_lo = 8'h18;
    localparam logic [7:0] off_cap1 = 8'h1c;
    localparam logic [7:0] off_cap2 = 8'h20;
    localparam logic [7:0] off_count = 8'h24;

    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [15:0] count_top = 16'hffff;
    localparam logic [15:0] cmp_reset = 16'h0000;
    localparam logic [15:0] cap_reset = 16'h0000;
    localparam logic [2:0] presc_reset = 3'h0;

    typedef enum logic [1:0] {
        clk_div2 = 2'b00,
        clk_div4 = 2'b01,
        clk_div8 = 2'b10,
        clk_ext = 2'b11
    } clk_sel_t;

    typedef enum logic {
        pw_run = 1'b0,
        pw_halt = 1'b1
    } power_state_t;

    // Control word, bit 0 upward: pin enables, levels, forces, modes, clock
    typedef struct packed {
        clk_sel_t clk_sel;
        logic pwm_mode;
        logic one_pulse_mode;
        logic [1:0] force_compare_level;
        logic [1:0] compare_output_level;
        logic [1:0] compare_pin_enable;
    } ctrl_t;

    localparam int ctrl_width = 10;
    localparam ctrl_t ctrl_reset = '{clk_sel: clk_div2, default: '0};

    // Event word, bit 0 upward: capture 1/2, compare 1/2, overflow
    typedef struct packed {
        logic overflow_flag;
        logic [1:0] compare_match_flag;
        logic [1:0] capture_event_flag;
    } evt_t;

    localparam int evt_width = 5;
    localparam evt_t evt_reset = '0;

endpackage

// [pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync
    import timer16_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.stage = {s_q.stage[1:0], pin};
        // Stage 0 feeds only stage 1; stages 1 and 2 must agree
        if (s_q.stage[1] == s_q.stage[2]) begin
            s_d.level = s_q.stage[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.level;
endmodule

// [cmp_channel.sv]
// One output compare channel: compare word, write inhibit, pin level
`timescale 1ns/100ps
module cmp_channel
    import timer16_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] count,
    input wire logic fresh,
    input wire logic plus_one,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wbyte,
    input wire logic level,
    input wire logic pin_enable,
    input wire logic force_on,
    input wire logic events_on,
    output logic [15:0] value,
    output logic match,
    output logic pin
);
    typedef struct packed {
        logic [15:0] value;
        logic inhibit;
        logic pin;
    } chan_t;

    chan_t c_q;
    chan_t c_d;
    logic [15:0] target;

    always_comb begin
        target = plus_one ? c_q.value + 16'h0001 : c_q.value; // R3 R4
        match = fresh && events_on && !c_q.inhibit && (count == target); // R16
        c_d = c_q;
        if (wr_hi) begin
            c_d.value[15:8] = wbyte;
            c_d.inhibit = 1'b1; // R1
        end
        if (wr_lo) begin
            c_d.value[7:0] = wbyte;
            c_d.inhibit = 1'b0; // R1
        end
        if (force_on) begin
            c_d.pin = level; // R7
        end else if (match && pin_enable) begin
            c_d.pin = level; // R2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= '{value: cmp_reset, default: '0};
        end else begin
            c_q <= c_d;
        end
    end

    assign value = c_q.value;
    assign pin = c_q.pin;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_inhibit_after_hi: assert property (wr_hi && !wr_lo |=> !match until wr_lo) // R1
        else $error("compare matched between high and low byte writes");
    a_force_copies: assert property (force_on |=> pin == $past(level)) // R7
        else $error("forced pin does not follow the level bit");
    a_match_offset: assert property (match |-> count == (plus_one ? value + 16'h0001 : value)) // R4
        else $error("compare matched at the wrong count");
endmodule

// [timer16_compare_events.sv]
// 16-bit timer: compare outputs, capture inputs, events and APB registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] High-byte write suspends compare until low byte
// [R2] Pin disabled: no level, flag still raised
// [R3] Divide-by-two clock: match at compare value
// [R4] Slower clocks: match at compare value plus one
// [R5] Compare and capture run at once
// [R6] Software reloads compare and level after match
// [R7] Force bit copies level bit to pin
// [R8] Forced output never sets compare flag
// [R9] Force ignored in one-pulse and PWM
// [R10] Wait: timer runs, interrupt wakes device
// [R11] Halt freezes counter; resumes from held count
// [R12] Capture during halt arms; flagged on exit
// [R13] Five events; no compare events in PWM
// [R14] Shared interrupt; enable and global mask gate
// [R15] Mode-dependent availability of capture and compare
// [R16] Full 16-bit compare on each timer clock
module timer16_compare_events
    import timer16_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] capture_input_pin,
    input wire logic ext_clock_pin,
    input wire logic cpu_int_masked,
    input wire logic wait_mode,
    input wire logic halt_mode,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_output_pin_oe,
    output logic timer_irq,
    output logic wait_wake
);
    typedef struct packed {
        ctrl_t ctrl;
        evt_t status;
        evt_t mask;
        logic [15:0] count;
        logic [2:0] presc;
        logic fresh;
        logic ext_prev;
        logic [1:0] cap_prev;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [1:0] armed;
        power_state_t pw;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic wake;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic [1:0] cap_level;
    logic ext_level;
    logic [15:0] cmp_value [2];
    logic [1:0] cmp_match;
    logic [1:0] cmp_pin;
    logic [1:0] wr_hi;
    logic [1:0] wr_lo;
    logic [1:0] force_on;
    logic [1:0] cmp_events_on;
    logic [1:0] cap_on;
    logic [1:0] cap_rise;
    logic ext_rise;
    logic tick;
    logic plus_one;
    logic wr_acc;
    logic rd_setup;
    logic wr_status;
    logic pwm_reload;
    logic irq_d;
    evt_t set_evt;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pins
            pin_sync u_cap_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin(capture_input_pin[gi]),
                .level(cap_level[gi])
            );
            cmp_channel u_cmp (
                .pclk(pclk),
                .presetn(presetn),
                .count(st_q.count),
                .fresh(st_q.fresh),
                .plus_one(plus_one),
                .wr_hi(wr_hi[gi]),
                .wr_lo(wr_lo[gi]),
                .wbyte(pwdata[7:0]),
                .level(st_q.ctrl.compare_output_level[gi]),
                .pin_enable(st_q.ctrl.compare_pin_enable[gi]),
                .force_on(force_on[gi]),
                .events_on(cmp_events_on[gi]),
                .value(cmp_value[gi]),
                .match(cmp_match[gi]),
                .pin(cmp_pin[gi])
            );
            // Force is a plain override; mode bits win over it
            assign force_on[gi] = st_q.ctrl.force_compare_level[gi]
                && !st_q.ctrl.one_pulse_mode && !st_q.ctrl.pwm_mode; // R9
        end
    endgenerate

    pin_sync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_clock_pin),
        .level(ext_level)
    );

    always_comb begin
        // Compare 2 stays usable in one-pulse mode, only partly meaningful
        cmp_events_on[0] = !st_q.ctrl.one_pulse_mode && !st_q.ctrl.pwm_mode; // R15
        cmp_events_on[1] = !st_q.ctrl.pwm_mode; // R13
        cap_on[0] = !st_q.ctrl.one_pulse_mode && !st_q.ctrl.pwm_mode; // R15
        cap_on[1] = 1'b1;
        cap_rise = cap_level & ~st_q.cap_prev;
        ext_rise = ext_level && !st_q.ext_prev;
        plus_one = (st_q.ctrl.clk_sel != clk_div2); // R3 R4
        case (st_q.ctrl.clk_sel)
            clk_div2: tick = st_q.presc[0];
            clk_div4: tick = &st_q.presc[1:0];
            clk_div8: tick = &st_q.presc;
            clk_ext: tick = ext_rise;
            default: tick = 1'b0;
        endcase
        tick = tick && !halt_mode; // R11
        // A tick taken just before halt must not reset the frozen count
        pwm_reload = st_q.ctrl.pwm_mode && st_q.fresh && !halt_mode
            && (st_q.count == cmp_value[0]); // R11
        rd_setup = psel && !penable;
        wr_acc = psel && penable && st_q.pready && pwrite;
        wr_status = wr_acc && (paddr == off_status);
        wr_hi[0] = wr_acc && (paddr == off_cmp1_hi);
        wr_lo[0] = wr_acc && (paddr == off_cmp1_lo);
        wr_hi[1] = wr_acc && (paddr == off_cmp2_hi);
        wr_lo[1] = wr_acc && (paddr == off_cmp2_lo);
    end

    always_comb begin
        st_d = st_q;
        set_evt = evt_reset;
        st_d.cap_prev = cap_level;
        st_d.ext_prev = ext_level;
        st_d.fresh = tick;
        if (!halt_mode) begin
            st_d.presc = st_q.presc + 3'h1; // R10
        end
        if (pwm_reload) begin
            st_d.count = count_reset;
            set_evt.capture_event_flag[0] = 1'b1; // R13
        end else if (tick) begin
            st_d.count = st_q.count + 16'h0001;
            if (st_q.count == count_top) begin
                set_evt.overflow_flag = 1'b1; // R13
            end
        end
        // Compare flags rise on a real match only, never on a force
        set_evt.compare_match_flag = cmp_match; // R2 R8
        st_d.pw = halt_mode ? pw_halt : pw_run;
        if (halt_mode) begin
            st_d.armed = st_q.armed | (cap_rise & cap_on); // R12
        end else if (st_q.pw == pw_halt) begin
            // Leaving halt: armed inputs catch the count held at exit
            if (st_q.armed[0]) begin
                st_d.cap1 = st_q.count; // R12
                set_evt.capture_event_flag[0] = 1'b1;
            end
            if (st_q.armed[1]) begin
                st_d.cap2 = st_q.count; // R12
                set_evt.capture_event_flag[1] = 1'b1;
            end
            st_d.armed = 2'b00;
        end else begin
            if (cap_rise[0] && cap_on[0]) begin
                st_d.cap1 = st_q.count; // R5
                set_evt.capture_event_flag[0] = 1'b1;
            end
            if (cap_rise[1] && cap_on[1]) begin
                st_d.cap2 = st_q.count; // R5
                set_evt.capture_event_flag[1] = 1'b1;
            end
        end
        // Set wins over a same-cycle write-one-to-clear
        st_d.status = set_evt | (st_q.status & ~(wr_status ? evt_t'(pwdata[4:0]) : evt_reset));
        if (wr_acc && (paddr == off_ctrl)) begin
            st_d.ctrl = ctrl_t'(pwdata[ctrl_width-1:0]);
        end
        if (wr_acc && (paddr == off_mask)) begin
            st_d.mask = evt_t'(pwdata[evt_width-1:0]);
        end
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (rd_setup) begin
            st_d.pready = 1'b1;
            st_d.prdata = 32'h0000_0000;
            case (paddr)
                off_ctrl: st_d.prdata[ctrl_width-1:0] = st_q.ctrl;
                off_status: st_d.prdata[evt_width-1:0] = st_q.status;
                off_mask: st_d.prdata[evt_width-1:0] = st_q.mask;
                off_cmp1_hi: st_d.prdata[7:0] = cmp_value[0][15:8];
                off_cmp1_lo: st_d.prdata[7:0] = cmp_value[0][7:0];
                off_cmp2_hi: st_d.prdata[7:0] = cmp_value[1][15:8];
                off_cmp2_lo: st_d.prdata[7:0] = cmp_value[1][7:0];
                off_cap1: st_d.prdata[15:0] = st_q.cap1;
                off_cap2: st_d.prdata[15:0] = st_q.cap2;
                off_count: st_d.prdata[15:0] = st_q.count;
                default: st_d.pslverr = 1'b1;
            endcase
        end
        irq_d = (|(st_d.status & st_d.mask)) && !cpu_int_masked; // R14
        st_d.irq = irq_d;
        // Halt is ended only by the CPU's other wake sources
        st_d.wake = irq_d && wait_mode; // R10
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{ctrl: ctrl_reset, status: evt_reset, mask: evt_reset,
                count: count_reset, presc: presc_reset, cap1: cap_reset,
                cap2: cap_reset, pw: pw_run, default: '0}; // R11
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign compare_output_pin = cmp_pin;
    // Disabled channel leaves the pin to ordinary port logic
    assign compare_output_pin_oe = st_q.ctrl.compare_pin_enable; // R2
    assign timer_irq = st_q.irq;
    assign wait_wake = st_q.wake;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_halt_exit(int i);
        st_q.pw == pw_halt && !halt_mode && st_q.armed[i];
    endsequence

    a_halt_freeze: assert property ($past(halt_mode) |-> $stable(st_q.count)) // R11
        else $error("counter moved during halt");
    a_halt_capture: assert property (s_halt_exit(1) |=>
        st_q.status.capture_event_flag[1] && st_q.cap2 == $past(st_q.count)) // R12
        else $error("armed capture not taken on halt exit");
    a_irq_gating: assert property (cpu_int_masked |=> !timer_irq) // R14
        else $error("interrupt raised while globally masked");
    a_irq_raise: assert property (!cpu_int_masked && |(st_q.status & st_q.mask)
        && !wr_status |=> timer_irq) // R14
        else $error("enabled pending event did not interrupt");
    a_pwm_no_cmp: assert property (st_q.ctrl.pwm_mode |-> cmp_match == 2'b00) // R13
        else $error("compare event while in PWM mode");
    a_overflow_wrap: assert property (tick && !pwm_reload && st_q.count == count_top |=>
        st_q.status.overflow_flag && st_q.count == count_reset) // R13
        else $error("overflow not flagged at wrap");
    a_set_wins: assert property (wr_status && pwdata[2] && cmp_match[0] |=>
        st_q.status.compare_match_flag[0]) // R8
        else $error("compare flag lost to a same-cycle clear");
    a_force_no_flag: assert property (force_on[0] && !cmp_match[0] && !wr_status
        && !st_q.status.compare_match_flag[0] |=> !st_q.status.compare_match_flag[0]) // R8
        else $error("forced output raised the compare flag");
    a_wait_wake: assert property (wait_mode && irq_d |=> wait_wake ##0 timer_irq) // R10
        else $error("pending interrupt did not wake from wait");
    a_apb_answer: assert property (psel && !penable |=> pready) // R14
        else $error("setup phase not answered in the next cycle");
endmodule

// [pin_partner.sv]
// Far-side circuitry: drives capture edges into the timer
`timescale 1ns/100ps
module pin_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] fire,
    output logic [1:0] capture_input_pin
);
    // Pulse is stretched past the three-flop filter, else it is lost
    logic [2:0] hold_q [2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q[0] <= 3'h0;
            hold_q[1] <= 3'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (fire[i]) begin
                    hold_q[i] <= 3'h6;
                end else if (hold_q[i] != 3'h0) begin
                    hold_q[i] <= hold_q[i] - 3'h1;
                end
            end
        end
    end
    // Idle level is low, as with a pull-down
    assign capture_input_pin = {hold_q[1] != 3'h0, hold_q[0] != 3'h0};
endmodule

// [testbench.sv]
// Self-checking bench for the compare/capture timer
`timescale 1ns/100ps
module testbench
    import timer16_pkg::*;
    ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] fire = 2'b00;
    logic ext_clk = 1'b0;
    logic [1:0] cap_pin;
    logic cpu_int_masked = 1'b0;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic [1:0] cmp_pin;
    logic [1:0] cmp_oe;
    logic timer_irq;
    logic wait_wake;
    logic [31:0] rdata;
    logic rerr;
    logic [15:0] tgt;
    logic [15:0] held;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #5 pclk = ~pclk;

    timer16_compare_events DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(cap_pin), .ext_clock_pin(ext_clk),
        .cpu_int_masked(cpu_int_masked), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .compare_output_pin(cmp_pin),
        .compare_output_pin_oe(cmp_oe), .timer_irq(timer_irq),
        .wait_wake(wait_wake));

    pin_partner partner (.pclk(pclk), .presetn(presetn), .fire(fire),
        .capture_input_pin(cap_pin));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("BAD %0t timeout", $time);
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench timeout ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // High byte first; the channel stays inhibited until the low byte lands
    task automatic set_cmp(input logic [7:0] hi, input logic [15:0] v);
        wr(hi, {24'h0, v[15:8]});
        wr(hi + 8'h04, {24'h0, v[7:0]});
    endtask

    task automatic pulse(input logic [1:0] ch);
        fire <= ch;
        @(posedge pclk);
        fire <= 2'b00;
    endtask

    task automatic wait_pin(input int ch, input logic v);
        int n;
        n = 0;
        while (cmp_pin[ch] !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, cmp_pin[ch]}, {31'h0, v}, "pin level");
    endtask

    task automatic t_reset();
        rd(off_ctrl);
        chk(rdata, 32'h0, "ctrl reset");
        rd(off_status);
        chk(rdata, 32'h0, "status reset");
        rd(off_mask);
        chk(rdata, 32'h0, "mask reset");
        rd(8'h3c);
        chk({31'h0, rerr}, 32'h1, "unmapped");
        chk({30'h0, cmp_oe}, 32'h0, "oe reset");
        $display("test reset done");
    endtask

    task automatic t_div2();
        wr(off_mask, 32'h04);
        wr(off_ctrl, 32'h005);
        rd(off_count);
        tgt = rdata[15:0] + 16'h0010;
        set_cmp(off_cmp1_hi, tgt);
        set_cmp(off_cmp2_hi, tgt);
        pulse(2'b01);
        wait_pin(0, 1'b1);
        rd(off_count);
        chk({31'h0, rdata[15:0] - tgt <= 16'h0002}, 32'h1, "match div2");
        chk({30'h0, cmp_pin}, 32'h1, "pin2 idle");
        chk({30'h0, cmp_oe}, 32'h1, "oe");
        rd(off_status);
        chk(rdata, 32'h0d, "flags");
        chk({31'h0, timer_irq}, 32'h1, "irq on");
        wait_mode <= 1'b1;
        rd(off_count);
        held = rdata[15:0];
        rd(off_count);
        chk({31'h0, rdata[15:0] != held}, 32'h1, "runs in wait");
        chk({31'h0, wait_wake}, 32'h1, "wake");
        cpu_int_masked <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, timer_irq}, 32'h0, "global mask");
        cpu_int_masked <= 1'b0;
        wr(off_status, 32'h04);
        @(posedge pclk);
        chk({31'h0, timer_irq}, 32'h0, "cleared");
        wait_mode <= 1'b0;
        $display("test div2 done");
    endtask

    task automatic t_div8();
        wr(off_ctrl, 32'h201);
        rd(off_count);
        tgt = rdata[15:0] + 16'h0004;
        set_cmp(off_cmp1_hi, tgt);
        wait_pin(0, 1'b0);
        rd(off_count);
        chk({16'h0, rdata[15:0]}, {16'h0, tgt + 16'h0001}, "match div8");
        $display("test div8 done");
    endtask

    task automatic t_inhibit();
        wr(off_status, 32'h1f);
        wr(off_ctrl, 32'h005);
        rd(off_count);
        tgt = rdata[15:0] + 16'h0010;
        set_cmp(off_cmp1_hi, tgt);
        wr(off_cmp1_hi, {24'h0, tgt[15:8]});
        repeat (60) @(posedge pclk);
        chk({30'h0, cmp_pin}, 32'h0, "inhibited");
        rd(off_status);
        chk(rdata & 32'h04, 32'h0, "no flag");
        rd(off_count);
        tgt = rdata[15:0] + 16'h0010;
        set_cmp(off_cmp1_hi, tgt);
        wait_pin(0, 1'b1);
        rd(off_status);
        chk(rdata & 32'h04, 32'h04, "flag after low");
        $display("test inhibit done");
    endtask

    task automatic t_force();
        wr(off_status, 32'h1f);
        wr(off_ctrl, 32'h013);
        wait_pin(0, 1'b0);
        wr(off_ctrl, 32'h017);
        wait_pin(0, 1'b1);
        rd(off_status);
        chk(rdata & 32'h0c, 32'h0, "forced no flag");
        wr(off_ctrl, 32'h053);
        repeat (8) @(posedge pclk);
        chk({31'h0, cmp_pin[0]}, 32'h1, "opm force");
        $display("test force done");
    endtask

    task automatic t_halt();
        wr(off_ctrl, 32'h001);
        wr(off_status, 32'h1f);
        halt_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(off_count);
        held = rdata[15:0];
        pulse(2'b10);
        repeat (8) @(posedge pclk);
        rd(off_count);
        chk({16'h0, rdata[15:0]}, {16'h0, held}, "frozen");
        rd(off_status);
        chk(rdata, 32'h0, "armed only");
        halt_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(off_status);
        chk(rdata & 32'h02, 32'h02, "flag at exit");
        rd(off_cap2);
        chk({31'h0, rdata[15:0] - held <= 16'h0001}, 32'h1, "capture exit");
        rd(off_count);
        chk({31'h0, rdata[15:0] - held <= 16'h0010}, 32'h1, "resume");
        $display("test halt done");
    endtask

    task automatic t_pwm();
        wr(off_status, 32'h1f);
        wr(off_ctrl, 32'h080);
        rd(off_count);
        tgt = rdata[15:0] + 16'h0010;
        set_cmp(off_cmp1_hi, tgt);
        set_cmp(off_cmp2_hi, tgt);
        repeat (100) @(posedge pclk);
        rd(off_count);
        chk({31'h0, rdata[15:0] < tgt - 16'h0010}, 32'h1, "pwm wrap");
        rd(off_status);
        chk(rdata & 32'h0d, 32'h01, "pwm events");
        $display("test pwm done");
    endtask

    // Pulses are held four cycles so the pin filter sees each one
    task automatic t_ext();
        logic [15:0] c0;
        wr(off_ctrl, 32'h300);
        rd(off_count);
        c0 = rdata[15:0];
        repeat (5) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        rd(off_count);
        chk({16'h0, rdata[15:0]}, {16'h0, c0 + 16'h0005}, "ext count");
        $display("test ext done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_div2();
        t_div8();
        t_inhibit();
        t_force();
        t_halt();
        t_pwm();
        t_ext();
        close_out();
    end
endmodule
